// File: hw/froc_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * free-run output compare block.
 * Assumes a 32-bit APB slave with each register on its own aligned word.
 */
`ifndef FROC_DEFS_SVH
`define FROC_DEFS_SVH

// ============================================================
// register indices (printed offsets); byte address = 4 * index
`define FROC_IDX_COUNT 8'h56
`define FROC_IDX_CTRL 8'h58
`define FROC_IDX_CMP0 8'h5a
`define FROC_IDX_CMP1 8'h5b
`define FROC_IDX_CSL 8'h62
`define FROC_IDX_CSH 8'h63
`define FROC_IDX_IRQ_STAT 8'h70
`define FROC_IDX_IRQ_EN 8'h71
`define FROC_IDX_IRQ_CLR 8'h72

// ============================================================
// timer control fields
`define FROC_CT_COUNT_CLOCK_SELECT_LO 0
`define FROC_CT_COUNT_CLOCK_SELECT_HI 1
`define FROC_CT_CLR 2
`define FROC_CT_MODE 3
`define FROC_CT_STOP 4
`define FROC_CT_OVFE 5
`define FROC_CT_OVF 6

// ============================================================
// compare control low fields (low byte) and high fields
`define FROC_CL_IRQ_EN_A 0
`define FROC_CL_IRQ_EN_B 1
`define FROC_CL_RUN_A 2
`define FROC_CL_RUN_B 3
`define FROC_CL_FLAG_A 4
`define FROC_CL_FLAG_B 5
`define FROC_CH_LEVEL_A 0
`define FROC_CH_LEVEL_B 1
`define FROC_CH_OE_A 2
`define FROC_CH_OE_B 3
`define FROC_CH_PAIRED 4

// ============================================================
// interrupt status bits
`define FROC_IS_MATCH_A 0
`define FROC_IS_MATCH_B 1
`define FROC_IS_OVF 2

// ============================================================
// reset values
`define FROC_RST_COUNT 16'h0000
`define FROC_RST_CTRL 8'h00
`define FROC_RST_CMP 16'h0000
`define FROC_RST_BYTE 8'h00

// ============================================================
// count clock prescale (machine clocks per count) per select code
`define FROC_DIV0 8'h01
`define FROC_DIV1 8'h04
`define FROC_DIV2 8'h10
`define FROC_DIV3 8'h40

`endif

// File: hw/froc_pkg.sv
/*
 * Types for the free-run output compare block.
 * Assumes froc_defs.svh holds all numbers.
 */
package froc_pkg;
    typedef logic [15:0] froc_word_t;
    typedef logic [7:0] froc_byte_t;
    typedef logic [1:0] froc_pair_t;
endpackage : froc_pkg

// File: hw/froc_top.sv
/*
 * Free-run output compare: a 16-bit up counter, two compare channels with
 * toggling output pins, match and overflow flags, and an APB register port.
 * Assumes a single 200 MHz clock, synchronous active-high reset and a
 * well-behaved APB master.
 */
`timescale 1ns/1ps
`include "froc_defs.svh"

module froc_top
(
    input wire logic clk, // machine clock
    input wire logic srst, // sync reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output froc_pkg::froc_pair_t cmp_out, // compare pin levels
    output froc_pkg::froc_pair_t cmp_oe, // compare pin drive enables
    output logic irq // level interrupt
);
    import froc_pkg::*;

    // ============================================================
    // bus decode
    function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
        hit = (a == {22'h0, idx, 2'b00});
    endfunction : hit

    logic acc;
    logic wr;
    logic mapped;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign pready = 1'b1;
    assign mapped = hit(paddr, `FROC_IDX_COUNT) | hit(paddr, `FROC_IDX_CTRL)
        | hit(paddr, `FROC_IDX_CMP0) | hit(paddr, `FROC_IDX_CMP1)
        | hit(paddr, `FROC_IDX_CSL) | hit(paddr, `FROC_IDX_CSH)
        | hit(paddr, `FROC_IDX_IRQ_STAT) | hit(paddr, `FROC_IDX_IRQ_EN)
        | hit(paddr, `FROC_IDX_IRQ_CLR);
    assign pslverr = acc & ~mapped;

    // ============================================================
    // state
    froc_word_t count_q, count_d;
    froc_byte_t ctrl_q, ctrl_d;
    froc_word_t cmp_q [2];
    froc_word_t cmp_d [2];
    froc_byte_t csl_q, csl_d;
    froc_byte_t csh_q, csh_d;
    froc_pair_t pin_q, pin_d;
    logic [2:0] ist_q, ist_d;
    logic [2:0] ien_q, ien_d;
    logic [7:0] pre_q, pre_d;
    logic [31:0] rd_q, rd_d;

    // count tick from the prescaler; compare is sampled on this tick
    logic tick;
    logic [7:0] div;
    logic [1:0] cmp_wr;
    froc_pair_t match;
    froc_pair_t tog;
    logic ovf_evt;
    logic mode_clr;

    always_comb
    begin
        case ({ctrl_q[`FROC_CT_COUNT_CLOCK_SELECT_HI], ctrl_q[`FROC_CT_COUNT_CLOCK_SELECT_LO]})
            2'd0: div = `FROC_DIV0;
            2'd1: div = `FROC_DIV1;
            2'd2: div = `FROC_DIV2;
            default: div = `FROC_DIV3;
        endcase
    end

    assign tick = ~ctrl_q[`FROC_CT_STOP] & (pre_q == div - 8'h01);
    assign cmp_wr[0] = wr & hit(paddr, `FROC_IDX_CMP0);
    assign cmp_wr[1] = wr & hit(paddr, `FROC_IDX_CMP1);

    // per-channel match, gated by run enable, tick and write hazard
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            assign match[g] = tick & csl_q[`FROC_CL_RUN_A + g]
                & ~cmp_wr[g]
                & (count_q == cmp_q[g]);
        end
    endgenerate

    // pin b follows either channel only in paired mode
    assign tog[0] = match[0];
    assign tog[1] = csh_q[`FROC_CH_PAIRED] ? (match[0] | match[1]) : match[1];
    assign mode_clr = match[0] & ctrl_q[`FROC_CT_MODE];
    assign ovf_evt = tick & (count_q == 16'hffff) & ~mode_clr;

    // ============================================================
    // prescaler and counter
    always_comb
    begin
        pre_d = pre_q;
        count_d = count_q;
        if (ctrl_q[`FROC_CT_STOP])
            pre_d = 8'h00;
        else if (tick)
            pre_d = 8'h00;
        else
            pre_d = pre_q + 8'h01;
        if (tick)
            count_d = mode_clr ? 16'h0000 : count_q + 16'h0001;
        if (wr & hit(paddr, `FROC_IDX_CTRL) & pwdata[`FROC_CT_CLR])
            count_d = 16'h0000;
        // direct load relies on software stopping the counter first
        if (wr & hit(paddr, `FROC_IDX_COUNT))
            count_d = pwdata[15:0];
    end

    // ============================================================
    // register file and flags
    always_comb
    begin
        ctrl_d = ctrl_q;
        cmp_d = cmp_q;
        csl_d = csl_q;
        csh_d = csh_q;
        ien_d = ien_q;
        pin_d = pin_q ^ tog;
        if (wr & hit(paddr, `FROC_IDX_CTRL))
            ctrl_d = {1'b0, ctrl_q[`FROC_CT_OVF] & pwdata[`FROC_CT_OVF], pwdata[5:3], 1'b0,
                pwdata[1:0]};
        if (ovf_evt | mode_clr)
            ctrl_d[`FROC_CT_OVF] = 1'b1; // set wins over clear
        for (int i = 0; i < 2; i++)
            if (cmp_wr[i])
                cmp_d[i] = pwdata[15:0];
        if (wr & hit(paddr, `FROC_IDX_CSL))
            csl_d = {2'b00, csl_q[5:4] & pwdata[5:4], pwdata[3:0]};
        for (int i = 0; i < 2; i++)
            if (match[i])
                csl_d[`FROC_CL_FLAG_A + i] = 1'b1;
        if (wr & hit(paddr, `FROC_IDX_CSH))
        begin
            csh_d = {3'b000, pwdata[4:0]};
            pin_d = pwdata[1:0];
        end
        if (wr & hit(paddr, `FROC_IDX_IRQ_EN))
            ien_d = pwdata[2:0];
    end

    // ============================================================
    // interrupt status: sticky, write-one-to-clear, events win
    always_comb
    begin
        ist_d = ist_q;
        if (wr & hit(paddr, `FROC_IDX_IRQ_CLR))
            ist_d = ist_q & ~pwdata[2:0];
        ist_d[`FROC_IS_MATCH_A] = ist_d[`FROC_IS_MATCH_A] | match[0];
        ist_d[`FROC_IS_MATCH_B] = ist_d[`FROC_IS_MATCH_B] | match[1];
        ist_d[`FROC_IS_OVF] = ist_d[`FROC_IS_OVF] | ovf_evt | mode_clr;
    end

    // ============================================================
    // read mux; rd_q registers it, but prdata takes the live rd_d value
    always_comb
    begin
        rd_d = rd_q;
        if (acc & ~pwrite)
        begin
            rd_d = 32'h0;
            if (hit(paddr, `FROC_IDX_COUNT))
                rd_d = {16'h0, count_q};
            if (hit(paddr, `FROC_IDX_CTRL))
                rd_d = {24'h0, ctrl_q};
            if (hit(paddr, `FROC_IDX_CMP0))
                rd_d = {16'h0, cmp_q[0]};
            if (hit(paddr, `FROC_IDX_CMP1))
                rd_d = {16'h0, cmp_q[1]};
            if (hit(paddr, `FROC_IDX_CSL))
                rd_d = {24'h0, csl_q};
            if (hit(paddr, `FROC_IDX_CSH))
                rd_d = {24'h0, csh_q[7:2], pin_q};
            if (hit(paddr, `FROC_IDX_IRQ_STAT))
                rd_d = {29'h0, ist_q};
            if (hit(paddr, `FROC_IDX_IRQ_EN))
                rd_d = {29'h0, ien_q};
        end
    end
    // read data is combinational off the registered mux would lag; use live value
    always_comb
    begin
        prdata = 32'h0;
        if (acc & ~pwrite)
            prdata = rd_d;
    end

    // ============================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count_q <= `FROC_RST_COUNT;
            ctrl_q <= `FROC_RST_CTRL;
            cmp_q[0] <= `FROC_RST_CMP;
            cmp_q[1] <= `FROC_RST_CMP;
            csl_q <= `FROC_RST_BYTE;
            csh_q <= `FROC_RST_BYTE;
            pin_q <= 2'b00;
            ist_q <= 3'b000;
            ien_q <= 3'b000;
            pre_q <= 8'h00;
            rd_q <= 32'h0;
        end
        else
        begin
            count_q <= count_d;
            ctrl_q <= ctrl_d;
            cmp_q <= cmp_d;
            csl_q <= csl_d;
            csh_q <= csh_d;
            pin_q <= pin_d;
            ist_q <= ist_d;
            ien_q <= ien_d;
            pre_q <= pre_d;
            rd_q <= rd_d;
        end
    end

    // ============================================================
    // outputs
    assign cmp_out = pin_q;
    assign cmp_oe = {csh_q[`FROC_CH_OE_B], csh_q[`FROC_CH_OE_A]};
    assign irq = |(ist_q & ien_q)
        | (csl_q[`FROC_CL_FLAG_A] & csl_q[`FROC_CL_IRQ_EN_A])
        | (csl_q[`FROC_CL_FLAG_B] & csl_q[`FROC_CL_IRQ_EN_B])
        | (ctrl_q[`FROC_CT_OVF] & ctrl_q[`FROC_CT_OVFE]);

endmodule : froc_top

// File: verification/froc_top_sva.sv
/* Port-level checker for froc_top, attached by bind.
   Assumes byte address = 4 * register index and zero-wait apb. */
`timescale 1ns/1ps
`include "froc_defs.svh"
// ============================================================
// checker
module froc_top_chk
(
    input wire logic clk, // machine clock
    input wire logic srst, // sync reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire froc_pkg::froc_pair_t cmp_out, // pin levels
    input wire froc_pkg::froc_pair_t cmp_oe, // pin enables
    input wire logic irq // interrupt
);
    import froc_pkg::*;
    logic [7:0] st_q; // paired, stop, ovfe, irq_en, csl enables
    logic [7:0] st_d;
    wire wr = psel && penable && pwrite;
    wire ctl_wr = wr && paddr == {22'h0, `FROC_IDX_CTRL, 2'b00};
    wire csl_wr = wr && paddr == {22'h0, `FROC_IDX_CSL, 2'b00};
    wire csh_wr = wr && paddr == {22'h0, `FROC_IDX_CSH, 2'b00};
    wire ien_wr = wr && paddr == {22'h0, `FROC_IDX_IRQ_EN, 2'b00};
    wire c0_wr = wr && paddr == {22'h0, `FROC_IDX_CMP0, 2'b00};
    wire c1_wr = wr && paddr == {22'h0, `FROC_IDX_CMP1, 2'b00};
    // shadow of control bits, so pins and irq can be judged without the body
    always_comb
    begin
        st_d = st_q;
        if (ctl_wr)
            st_d[6:5] = {pwdata[4], pwdata[5]};
        if (csl_wr)
            st_d[1:0] = pwdata[1:0];
        if (ien_wr)
            st_d[4:2] = pwdata[2:0];
        if (csh_wr)
            st_d[7] = pwdata[4];
    end
    // shadow register
    always_ff @(posedge clk)
    begin
        if (srst)
            st_q <= 8'h00;
        else
            st_q <= st_d;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // ============================================================
    // assertions
    a_reset_idle: assert property ($fell(srst) |-> cmp_oe == 2'b00 && cmp_out == 2'b00 && !irq)
        else $error("pins or irq active after reset");
    a_cmp0_quiet: assert property (c0_wr |=> $stable(cmp_out[0]))
        else $error("pin a moved on compare write");
    a_cmp1_quiet: assert property (c1_wr && !st_q[7] |=> $stable(cmp_out[1]))
        else $error("pin b moved on compare write");
    a_level_set: assert property (csh_wr |=> cmp_out == $past(pwdata[1:0]))
        else $error("pin level not taken from write");
    a_oe_value: assert property (csh_wr |=> cmp_oe == $past(pwdata[3:2]))
        else $error("pin enable not taken from write");
    a_oe_held: assert property (!csh_wr |=> $stable(cmp_oe))
        else $error("pin enable moved without write");
    a_stop_quiet: assert property (st_q[6] && !csh_wr |=> $stable(cmp_out))
        else $error("pin toggled while counter stopped");
    a_irq_masked: assert property (st_q[5:0] == 6'h00 |-> !irq)
        else $error("irq with all enables clear");
    c_toggle: cover property (!csh_wr ##1 $changed(cmp_out));
    c_irq: cover property ($rose(irq));
    c_cmp_wr: cover property (c0_wr);
endmodule : froc_top_chk

bind froc_top froc_top_chk chk_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_out(cmp_out), .cmp_oe(cmp_oe), .irq(irq));

// File: verification/froc_top_tb_top.sv
/* Directed bench for froc_top: reset, match, pairing, stop, overflow, irq.
   Assumes zero-wait apb and count divide code 0 (one count per clock). */
`timescale 1ns/1ps
`include "froc_defs.svh"
// ============================================================
// bench top
module froc_top_tb_top;
    import froc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic slv;
    froc_pair_t cmp_out;
    froc_pair_t cmp_oe;
    logic irq;
    int err_total = 0;
    int cmp_count = 0;
    froc_top dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_out(cmp_out), .cmp_oe(cmp_oe), .irq(irq));
    // 200 MHz clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // one apb transfer; idle edge after it so drivers never collide
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // bounded wait for a pin pattern, then judge it
    task automatic wait_out(input logic [1:0] v);
        for (int n = 0; n < 80 && cmp_out !== v; n++)
            @(posedge clk);
        chk({30'h0, cmp_out}, {30'h0, v});
    endtask : wait_out
    task automatic close_out();
        $display("compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic t_reset();
        chk({29'h0, irq, cmp_oe}, 32'h0);
        bus(1'b0, `FROC_IDX_COUNT, 32'h0);
        chk({31'h0, rd[15:0] < 16'h0010}, 32'h1);
        bus(1'b0, 8'h00, 32'h0);
        chk({slv, rd[30:0]}, 32'h8000_0000);
    endtask : t_reset
    task automatic t_match();
        bus(1'b1, `FROC_IDX_CTRL, 32'h10);
        bus(1'b1, `FROC_IDX_COUNT, 32'h0100);
        bus(1'b1, `FROC_IDX_CMP0, 32'h0110);
        bus(1'b1, `FROC_IDX_CSH, 32'h04);
        bus(1'b1, `FROC_IDX_CTRL, 32'h00);
        bus(1'b1, `FROC_IDX_CSL, 32'h05);
        wait_out(2'b01);
        bus(1'b0, `FROC_IDX_CSL, 32'h0);
        chk({30'h0, rd[4], irq}, 32'h3);
        bus(1'b1, `FROC_IDX_CSL, 32'h05);
        bus(1'b0, `FROC_IDX_CSL, 32'h0);
        chk({30'h0, rd[4], irq}, 32'h0);
    endtask : t_match
    // pin b sees one toggle unpaired, two when paired; stop freezes pins
    task automatic t_pairs();
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, `FROC_IDX_CTRL, 32'h10);
            bus(1'b1, `FROC_IDX_COUNT, 32'h0200);
            bus(1'b1, `FROC_IDX_CMP0, 32'h0210);
            bus(1'b1, `FROC_IDX_CMP1, 32'h0208);
            bus(1'b1, `FROC_IDX_CSH, {27'h0, i[0], 4'hc});
            bus(1'b1, `FROC_IDX_CTRL, 32'h00);
            bus(1'b1, `FROC_IDX_CSL, 32'h0c);
            wait_out(i[0] ? 2'b01 : 2'b11);
        end
        bus(1'b1, `FROC_IDX_CTRL, 32'h10);
        bus(1'b1, `FROC_IDX_COUNT, 32'h0210);
        repeat (20) @(posedge clk);
        chk({30'h0, cmp_out}, 32'h1);
        bus(1'b1, `FROC_IDX_CSH, 32'h0e);
        chk({28'h0, cmp_oe, cmp_out}, 32'he);
    endtask : t_pairs
    task automatic t_ovf_irq();
        bus(1'b1, `FROC_IDX_COUNT, 32'hfff0);
        bus(1'b1, `FROC_IDX_CTRL, 32'h20);
        for (int n = 0; n < 80 && irq !== 1'b1; n++)
            @(posedge clk);
        bus(1'b0, `FROC_IDX_CTRL, 32'h0);
        chk({30'h0, rd[6], irq}, 32'h3);
        bus(1'b1, `FROC_IDX_CTRL, 32'h10);
        bus(1'b0, `FROC_IDX_IRQ_STAT, 32'h0);
        chk({28'h0, irq, rd[2:0]}, 32'h7);
        bus(1'b1, `FROC_IDX_IRQ_EN, 32'h7);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `FROC_IDX_IRQ_CLR, 32'h7);
        bus(1'b0, `FROC_IDX_IRQ_STAT, 32'h0);
        chk({28'h0, irq, rd[2:0]}, 32'h0);
    endtask : t_ovf_irq
    task automatic t_mode();
        bus(1'b1, `FROC_IDX_COUNT, 32'h0300);
        bus(1'b1, `FROC_IDX_CMP0, 32'h0308);
        bus(1'b1, `FROC_IDX_CTRL, 32'h08);
        wait_out(2'b11);
        bus(1'b0, `FROC_IDX_COUNT, 32'h0);
        chk({31'h0, rd[15:0] < 16'h0010}, 32'h1);
    endtask : t_mode
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_match();
        t_pairs();
        t_ovf_irq();
        t_mode();
        close_out();
    end
    // watchdog against a hung wait
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule : froc_top_tb_top
